//--- rtl/cjump_defs.svh
// constants for the conditional jump unit: opcodes, fields, offsets
`ifndef CJUMP_DEFS_SVH
`define CJUMP_DEFS_SVH

// ==========================================================
// code address and instruction fields
`define CJ_PC_W        10
`define CJ_OFF_W       5
`define CJ_REL_OPC     7'h12
`define CJ_ABS_OPC     6'h0f
`define CJ_ABS_TAIL    4'h4
`define CJ_SEL_MSB     8
`define CJ_SEL_LSB     5
`define CJ_POL_BIT     9
`define CJ_JRSEL_BIT   4
`define CJ_PC_RESET    10'h000

// ==========================================================
// register indices and byte addresses
`define CJ_IDX_CORE0   10'h101
`define CJ_IDX_CORE1   10'h102
`define CJ_ADDR_CORE0  ({`CJ_IDX_CORE0, 2'b00})
`define CJ_ADDR_CORE1  ({`CJ_IDX_CORE1, 2'b00})
`define CJ_ADDR_JTA    12'h000
`define CJ_ADDR_JTB    12'h004
`define CJ_ADDR_STAT   12'h008
`define CJ_CTL_RESET   16'h0000
`define CJ_JT_RESET    10'h000

// ==========================================================
// status register layout
`define CJ_STAT_KIND_LSB  16
`define CJ_STAT_TAKEN_BIT 20

`endif

//--- rtl/cjump_pkg.sv
// types used by the conditional jump unit for decode and register selection
package cjump_pkg;

    // ======================================================
    // decoded instruction class
    typedef enum logic [1:0] {
        kind_none,
        kind_rel,
        kind_abs
    } jump_kind_t;

    // ======================================================
    // register selected by an apb address
    typedef enum logic [2:0] {
        reg_none,
        reg_core0,
        reg_core1,
        reg_jta,
        reg_jtb,
        reg_stat
    } reg_sel_t;

endpackage : cjump_pkg

//--- rtl/ctl_bit_store.sv
// two-word store for the per-core control registers
`timescale 1ns/1ps
`default_nettype none
`include "cjump_defs.svh"

module ctl_bit_store #(
    parameter int WORDS = 2,
    parameter int W     = 16
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           clk_en,
    input  wire logic           wr_en,
    input  wire logic           wr_index,
    input  wire logic [W-1:0]   wr_data,
    input  wire logic           rd_en,
    input  wire logic           rd_index,
    output logic      [W-1:0]   rd_data,
    output logic [WORDS*W-1:0]  words
);

    // ======================================================
    // storage words, each one a plain register with a single driver
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        logic [W-1:0] word_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word_q <= `CJ_CTL_RESET;
            end else if (clk_en && wr_en && (wr_index == 1'(i))) begin
                word_q <= wr_data;
            end
        end
        // parallel view: jump logic must see all bits every cycle
        assign words[i*W +: W] = word_q;
    end

    // ======================================================
    // registered read port, loaded during the apb setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else if (clk_en && rd_en) begin
            rd_data <= words[rd_index*W +: W];
        end
    end

endmodule // ctl_bit_store

`default_nettype wire

//--- rtl/conditional_jump_unit.sv
// conditional jump decode, branch target and program counter
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cjump_defs.svh"

// Behaviour
// RQ1: relative jump opcode 0010010, selector, offset fields
// RQ2: true flag loads pc with relative target
// RQ3: offset is 5-bit signed, -16 to +15
// RQ4: target is jump address plus offset
// RQ5: test one alu flag named by selector
// RQ6: codes 0-4 completion and over/underflow flags
// RQ7: codes 5-8 sign, zero, multiply flags
// RQ8: codes 9/10 mask all ones, all zeros
// RQ9: code 11 not saturation, 12 positive mode
// RQ10: codes 13-15 carry, conversion sign, shift carry
// RQ11: absolute jump opcode 001111, tail 0100
// RQ12: matching control bit loads pc from jump register
// RQ13: absolute target reaches whole code memory
// RQ14: selector picks control bit 0 to 15
// RQ15: polarity picks active bit level
// RQ16: executing core's control register supplies the bit
// RQ17: untaken condition advances pc by one
// RQ18: register operand 0 first, 1 second target
// RQ19: sign extend to 10 bits, drop carry

module conditional_jump_unit #(
    parameter int PC_W = `CJ_PC_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             instr_valid,
    input  wire logic [15:0]      instr_word,
    input  wire logic             core_sel,
    input  wire logic             flag_op_done,
    input  wire logic             flag_ovf_s,
    input  wire logic             flag_unf_s,
    input  wire logic             flag_ovf_u,
    input  wire logic             flag_unf_u,
    input  wire logic             flag_sign,
    input  wire logic             flag_zero,
    input  wire logic             flag_mul_loss,
    input  wire logic             flag_mul_ovf,
    input  wire logic             mask_ones_flag,
    input  wire logic             mask_zeros_flag,
    input  wire logic             sat_enable,
    input  wire logic             positive_mode,
    input  wire logic             flag_carry,
    input  wire logic             flag_conv_sign,
    input  wire logic             flag_shift_carry,
    output logic      [PC_W-1:0]  program_counter,
    output logic                  jump_decoded,
    output logic                  jump_taken
);

    // ======================================================
    // decode helpers
    function automatic cjump_pkg::jump_kind_t decode_kind(
        input logic [15:0] w
    );
        if (w[15:9] == `CJ_REL_OPC) begin
            return cjump_pkg::kind_rel;
        end else if (w[15:10] == `CJ_ABS_OPC &&
                     w[3:0] == `CJ_ABS_TAIL) begin
            return cjump_pkg::kind_abs;
        end
        return cjump_pkg::kind_none;
    endfunction

    // one bit out of sixteen, for flags and control bits alike
    function automatic logic pick_bit(
        input logic [15:0] v,
        input logic [3:0]  s
    );
        return v[s];
    endfunction

    function automatic cjump_pkg::reg_sel_t decode_reg(
        input logic [11:0] a
    );
        case (a)
            `CJ_ADDR_CORE0: return cjump_pkg::reg_core0;
            `CJ_ADDR_CORE1: return cjump_pkg::reg_core1;
            `CJ_ADDR_JTA:   return cjump_pkg::reg_jta;
            `CJ_ADDR_JTB:   return cjump_pkg::reg_jtb;
            `CJ_ADDR_STAT:  return cjump_pkg::reg_stat;
            default:        return cjump_pkg::reg_none;
        endcase
    endfunction

    cjump_pkg::jump_kind_t  kind;
    cjump_pkg::jump_kind_t  last_kind;
    cjump_pkg::reg_sel_t    reg_sel;
    logic                   fire;
    logic [3:0]             sel;
    logic [15:0]            alu_cond;
    logic [31:0]            ctl_words;
    logic [15:0]            core0_control_bits;
    logic [15:0]            core1_control_bits;
    logic [15:0]            ctl_word;
    logic                   cond_true;
    logic [PC_W-1:0]        jump_target_a;
    logic [PC_W-1:0]        jump_target_b;
    logic [PC_W-1:0]        off_sext;
    logic [PC_W-1:0]        rel_target;
    logic [PC_W-1:0]        abs_target;
    logic [PC_W-1:0]        next_pc;
    logic                   last_taken;
    logic                   setup;
    logic                   access;
    logic                   sel_mem;
    logic [31:0]            own_rdata;
    logic [15:0]            mem_rdata;

    // ======================================================
    // instruction fields
    assign fire = clk_en && instr_valid;
    assign kind = decode_kind(instr_word);                  // [RQ1] [RQ11]
    assign sel  = instr_word[`CJ_SEL_MSB:`CJ_SEL_LSB];

    // flag vector indexed directly by the selector code
    assign alu_cond = {flag_shift_carry,                    // [RQ10]
                       flag_conv_sign,
                       flag_carry,
                       positive_mode,                       // [RQ9]
                       !sat_enable,
                       mask_zeros_flag,                     // [RQ8]
                       mask_ones_flag,
                       flag_mul_ovf,                        // [RQ7]
                       flag_mul_loss,
                       flag_zero,
                       flag_sign,
                       flag_unf_u,                          // [RQ6]
                       flag_ovf_u,
                       flag_unf_s,
                       flag_ovf_s,
                       flag_op_done};

    // the control word of whichever core is executing
    assign core0_control_bits = ctl_words[15:0];
    assign core1_control_bits = ctl_words[31:16];
    assign ctl_word = core_sel ? core1_control_bits
                               : core0_control_bits;        // [RQ16]

    // ======================================================
    // condition evaluation
    always_comb begin
        case (kind)
            cjump_pkg::kind_rel:
                cond_true = pick_bit(alu_cond, sel);        // [RQ5]
            cjump_pkg::kind_abs:
                cond_true = pick_bit(ctl_word, sel) ==      // [RQ14]
                            instr_word[`CJ_POL_BIT];        // [RQ15]
            default:
                cond_true = 1'b0;
        endcase
    end

    // ======================================================
    // targets; the sum wraps inside the code address width
    assign off_sext = {{(PC_W-`CJ_OFF_W){instr_word[`CJ_OFF_W-1]}},
                       instr_word[`CJ_OFF_W-1:0]};          // [RQ3] [RQ19]
    assign rel_target = program_counter + off_sext;         // [RQ4] [RQ19]
    assign abs_target = instr_word[`CJ_JRSEL_BIT] ?
                        jump_target_b : jump_target_a;      // [RQ18] [RQ13]

    always_comb begin
        next_pc = program_counter + PC_W'(1);               // [RQ17]
        if (kind == cjump_pkg::kind_rel && cond_true) begin
            next_pc = rel_target;                           // [RQ2]
        end else if (kind == cjump_pkg::kind_abs && cond_true) begin
            next_pc = abs_target;                           // [RQ12]
        end
    end

    // ======================================================
    // program counter, one step per accepted instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter <= `CJ_PC_RESET;
        end else if (fire) begin
            program_counter <= next_pc;                     // [RQ2] [RQ12]
        end
    end

    // one-cycle flags and sticky record of the last jump seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_decoded <= 1'b0;
            jump_taken   <= 1'b0;
            last_kind    <= cjump_pkg::kind_none;
            last_taken   <= 1'b0;
        end else if (clk_en) begin
            jump_decoded <= fire && kind != cjump_pkg::kind_none;
            jump_taken   <= fire && cond_true;
            if (fire && kind != cjump_pkg::kind_none) begin
                last_kind  <= kind;
                last_taken <= cond_true;
            end
        end
    end

    // ======================================================
    // apb slave: zero wait states unless the clock is frozen
    assign reg_sel = decode_reg(paddr);
    assign setup   = clk_en && psel && !penable;
    assign access  = clk_en && psel && penable;
    assign pready  = clk_en;
    assign pslverr = psel && penable &&
                     reg_sel == cjump_pkg::reg_none;

    // jump registers, written by software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_target_a <= `CJ_JT_RESET;
            jump_target_b <= `CJ_JT_RESET;
        end else if (access && pwrite) begin
            if (reg_sel == cjump_pkg::reg_jta) begin
                jump_target_a <= pwdata[PC_W-1:0];
            end
            if (reg_sel == cjump_pkg::reg_jtb) begin
                jump_target_b <= pwdata[PC_W-1:0];
            end
        end
    end

    // read data is sampled at setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_rdata <= '0;
            sel_mem   <= 1'b0;
        end else if (setup) begin
            sel_mem   <= reg_sel == cjump_pkg::reg_core0 ||
                         reg_sel == cjump_pkg::reg_core1;
            own_rdata <= '0;
            case (reg_sel)
                cjump_pkg::reg_jta:
                    own_rdata[PC_W-1:0] <= jump_target_a;
                cjump_pkg::reg_jtb:
                    own_rdata[PC_W-1:0] <= jump_target_b;
                cjump_pkg::reg_stat: begin
                    own_rdata[PC_W-1:0] <= program_counter;
                    own_rdata[`CJ_STAT_KIND_LSB +: 2] <= last_kind;
                    own_rdata[`CJ_STAT_TAKEN_BIT] <= last_taken;
                end
                default:
                    own_rdata <= '0;
            endcase
        end
    end

    assign prdata = sel_mem ? {16'h0000, mem_rdata} : own_rdata;

    // control registers of both cores
    ctl_bit_store #(
        .WORDS (2),
        .W     (16)
    ) ctl_bit_store_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .wr_en    (psel && penable && pwrite &&
                   (reg_sel == cjump_pkg::reg_core0 ||
                    reg_sel == cjump_pkg::reg_core1)),
        .wr_index (reg_sel == cjump_pkg::reg_core1),
        .wr_data  (pwdata[15:0]),
        .rd_en    (setup),
        .rd_index (reg_sel == cjump_pkg::reg_core1),
        .rd_data  (mem_rdata),
        .words    (ctl_words)
    );

    // ======================================================
    // checks; helpers recompute targets independently
    logic [PC_W-1:0] chk_off;
    logic [PC_W-1:0] chk_abs;
    logic            chk_hit0;
    logic            chk_rel;
    logic            chk_absop;

    assign chk_off   = PC_W'($signed(instr_word[4:0]));
    assign chk_abs   = instr_word[4] ? jump_target_b : jump_target_a;
    assign chk_hit0  = core0_control_bits[instr_word[8:5]] ==
                       instr_word[9];
    assign chk_rel   = fire && instr_word[15:9] == 7'b0010010;
    assign chk_absop = fire && instr_word[15:10] == 6'b001111 &&
                       instr_word[3:0] == 4'b0100;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rel_decode;
        chk_rel && alu_cond[instr_word[8:5]] |=> jump_taken;
    endproperty
    a_rel_decode: assert property (p_rel_decode) // [RQ1]
        else $error("relative jump not taken on true flag");

    property p_rel_target;
        chk_rel && alu_cond[instr_word[8:5]] |=>
            program_counter == $past(program_counter) + $past(chk_off);
    endproperty
    a_rel_target: assert property (p_rel_target) // [RQ2] [RQ3] [RQ4]
        else $error("relative target wrong");

    property p_rel_false;
        chk_rel && !alu_cond[instr_word[8:5]] |=> !jump_taken;
    endproperty
    a_rel_false: assert property (p_rel_false) // [RQ5]
        else $error("relative jump taken on false flag");

    property p_ovf_s;
        chk_rel && instr_word[8:5] == 4'h1 |=>
            jump_taken == $past(flag_ovf_s);
    endproperty
    a_ovf_s: assert property (p_ovf_s) // [RQ6]
        else $error("code 1 does not follow signed overflow");

    property p_zero;
        chk_rel && instr_word[8:5] == 4'h6 |=>
            jump_taken == $past(flag_zero);
    endproperty
    a_zero: assert property (p_zero) // [RQ7]
        else $error("code 6 does not follow zero flag");

    property p_ones;
        chk_rel && instr_word[8:5] == 4'h9 |=>
            jump_taken == $past(mask_ones_flag);
    endproperty
    a_ones: assert property (p_ones) // [RQ8]
        else $error("code 9 does not follow mask ones");

    property p_sat;
        chk_rel && instr_word[8:5] == 4'hb |=>
            jump_taken != $past(sat_enable);
    endproperty
    a_sat: assert property (p_sat) // [RQ9]
        else $error("code 11 does not invert saturation");

    property p_csh;
        chk_rel && instr_word[8:5] == 4'hf |=>
            jump_taken == $past(flag_shift_carry);
    endproperty
    a_csh: assert property (p_csh) // [RQ10]
        else $error("code 15 does not follow shift carry");

    property p_abs_tail;
        fire && instr_word[15:10] == 6'b001111 &&
        instr_word[3:0] != 4'b0100 |=> !jump_decoded;
    endproperty
    a_abs_tail: assert property (p_abs_tail) // [RQ11]
        else $error("wrong tail decoded as absolute jump");

    property p_abs_target;
        chk_absop && cond_true |=>
            program_counter == $past(chk_abs);
    endproperty
    a_abs_target: assert property (p_abs_target) // [RQ12] [RQ13] [RQ18]
        else $error("absolute target wrong");

    property p_core0_bit;
        chk_absop && !core_sel |=> jump_taken == $past(chk_hit0);
    endproperty
    a_core0_bit: assert property (p_core0_bit) // [RQ14] [RQ15] [RQ16]
        else $error("control bit test wrong for core 0");

    property p_seq;
        fire && !cond_true |=>
            program_counter == $past(program_counter) + PC_W'(1);
    endproperty
    a_seq: assert property (p_seq) // [RQ17] [RQ19]
        else $error("untaken step not sequential");

    property p_freeze;
        !clk_en ##1 !clk_en |-> $stable(program_counter);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("pc moved while clock disabled");

    c_rel_back: cover property (chk_rel && cond_true && instr_word[4]);
    c_abs_b: cover property (chk_absop && cond_true && instr_word[4]);
    c_abs_core1: cover property (chk_absop && core_sel && cond_true);
    c_wrap: cover property (chk_rel && cond_true &&
                            program_counter == '0 && instr_word[4]);

endmodule // conditional_jump_unit

`default_nettype wire

//--- test/tb_conditional_jump_unit.sv
// self-checking bench for the conditional jump unit
`timescale 1ns/1ps
`default_nettype none
`include "cjump_defs.svh"

module tb_conditional_jump_unit;
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        clk_en      = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word  = 16'h0;
    logic        core_sel    = 1'b0;
    logic [15:0] fl          = 16'h0;
    logic [9:0]  program_counter;
    logic        jump_decoded;
    logic        jump_taken;
    logic [9:0]  exp_pc;
    logic [15:0] ctl [2];
    logic [9:0]  jt [2];
    logic [31:0] rd;
    logic        err;
    logic        last_tk;
    int          fail_count  = 0;
    int          tests_run   = 0;

    // ==========================================================
    // clock and design
    always #20 pclk = ~pclk;

    conditional_jump_unit conditional_jump_unit_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .core_sel(core_sel), .flag_op_done(fl[0]), .flag_ovf_s(fl[1]),
        .flag_unf_s(fl[2]), .flag_ovf_u(fl[3]), .flag_unf_u(fl[4]),
        .flag_sign(fl[5]), .flag_zero(fl[6]), .flag_mul_loss(fl[7]),
        .flag_mul_ovf(fl[8]), .mask_ones_flag(fl[9]),
        .mask_zeros_flag(fl[10]), .sat_enable(~fl[11]),
        .positive_mode(fl[12]), .flag_carry(fl[13]),
        .flag_conv_sign(fl[14]), .flag_shift_carry(fl[15]),
        .program_counter(program_counter), .jump_decoded(jump_decoded),
        .jump_taken(jump_taken)
    );

    // ==========================================================
    // compare and closing report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // apb master: holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            fail_count++;
            results();
        end else begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // ==========================================================
    // instruction driver; pc model kept here, not read back
    task automatic ins(input logic [15:0] w, input logic [15:0] f,
                       input logic cs, input logic dec, input logic tk,
                       input logic [9:0] tgt);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        fl          <= f;
        core_sel    <= cs;
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1;
        exp_pc = tk ? tgt : exp_pc + 10'd1;
        last_tk = tk;
        check(32'(jump_decoded), 32'(dec));
        check(32'(jump_taken), 32'(tk));
        check(32'(program_counter), 32'(exp_pc));
    endtask

    // relative jump: target from the jump's own address
    task automatic rel(input logic [3:0] s, input logic [4:0] off,
                       input logic [15:0] f);
        ins({7'b0010010, s, off}, f, 1'b0, 1'b1, f[s],
            exp_pc + {{5{off[4]}}, off});
    endtask

    // absolute jump: selected control bit against polarity
    task automatic abs(input logic pol, input logic [3:0] s,
                       input logic jr, input logic cs);
        ins({6'b001111, pol, s, jr, 4'b0100}, 16'h0, cs, 1'b1,
            ctl[cs][s] == pol, jt[jr]);
    endtask

    // ==========================================================
    // main sequence
    logic [11:0] ra [4];
    logic [31:0] rm [4];
    initial begin
        ra = '{`CJ_ADDR_JTA, `CJ_ADDR_JTB, `CJ_ADDR_CORE0, `CJ_ADDR_CORE1};
        rm = '{32'h3ff, 32'h3ff, 32'hffff, 32'hffff};
        jt = '{10'h3ab, 10'h155};
        ctl = '{16'ha5c3, 16'h5a3c};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        exp_pc = 10'h000;
        #1 check(32'(program_counter), 32'h0);
        // reset values of both jump registers and both control registers are zero
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, 32'h0);
        end
        // offset -1 from address 0 wraps, then +1 wraps back
        rel(4'h0, 5'h1f, 16'h0001);
        rel(4'h0, 5'h01, 16'h0001);
        // upper bits written as ones must read back as zero
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ra[i], 32'hfffe_0000 | (i < 2 ? jt[i] : ctl[i-2]));
            apb(1'b0, ra[i], 32'h0);
            check(rd, (i < 2 ? 32'(jt[i]) : 32'(ctl[i-2])) & rm[i]);
        end
        // unmapped and unaligned places answer with an error
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h402, 32'hffff);
        check(32'(err), 32'h1);
        // every flag code, taken when only its flag is set
        for (int s = 0; s < 16; s++) begin
            rel(4'(s), 5'(s - 8), 16'h1 << s);
            rel(4'(s), 5'(s), ~(16'h1 << s));
        end
        // offset extremes
        rel(4'h5, 5'h10, 16'h0020);
        rel(4'h5, 5'h0f, 16'h0020);
        // every control bit, both polarities, both cores and targets
        for (int s = 0; s < 16; s++) begin
            for (int p = 0; p < 2; p++) begin
                abs(1'(p), 4'(s), 1'(s ^ p), 1'(s >> 1));
            end
        end
        abs(1'b1, 4'h0, 1'b1, 1'b0);
        abs(1'b1, 4'h0, 1'b0, 1'b1);
        // status reflects last jump; writes to it are dropped
        apb(1'b1, `CJ_ADDR_STAT, 32'h0);
        check(32'(err), 32'h0);
        apb(1'b0, `CJ_ADDR_STAT, 32'h0);
        check(rd, {11'h0, last_tk, 2'b00, 2'd2, 6'h0, exp_pc});
        // pulses last one cycle only
        @(posedge pclk);
        #1 check({jump_decoded, jump_taken}, 32'h0);
        // near misses of both opcodes advance by one
        ins(16'h3c05, 16'hffff, 1'b0, 1'b0, 1'b0, 10'h0);
        ins(16'h2682, 16'hffff, 1'b0, 1'b0, 1'b0, 10'h0);
        // clock enable low freezes pc and withholds pready
        @(posedge pclk);
        clk_en      <= 1'b0;
        instr_valid <= 1'b1;
        instr_word  <= 16'h2485;
        repeat (3) @(posedge pclk);
        #1 check({pready, 6'h0, program_counter}, 32'(exp_pc));
        @(posedge pclk);
        clk_en      <= 1'b1;
        instr_valid <= 1'b0;
        @(posedge pclk);
        #1 check(32'(program_counter), 32'(exp_pc));
        results();
    end
endmodule // tb_conditional_jump_unit

`default_nettype wire
